// File: core/acs_cal_sequencer.sv
/*
 * core calibration sequencer: foreground runs with midcode output,
 * background rotation of a spare core, low-power sleep/wake pacing,
 * factory trim load and an AXI4-Lite register slave.
 * assumes core_data, factory_trim and the bus are on mclk; the trigger pin
 * is asynchronous.
 */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
//
// Behaviour
// - foreground run forces midcode, cores offline
// - six banks, three cores, pairs out of phase
// - dual: A,B separate; single: both one input
// - background swaps core C in for A, B
// - calibration uses internal stimulus only
// - trims load factory values, software rewrites
// - foreground run at power-up; host waits
// - trigger from pin or software, selectable
// - background cycle repeats: calibrate, swap, rotate
// - low-power mode keeps offline spare powered down
// - sleep delay paces auto swaps
// - wake delay before calibrating woken core
// - swap automatic or user-triggered
// - done bit reports foreground completion
`timescale 1ns/10ps
module acs_cal_sequencer
   import acs_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cal_trigger_pin,
   input  wire logic [23:0] core_data,
   input  wire logic [23:0] factory_trim,
   output logic [7:0]       ch_a_data,
   output logic [7:0]       ch_b_data,
   output logic [2:0]       core_power,
   output logic [5:0]       bank_sample,
   output logic [2:0]       core_input_sel,
   output logic [2:0]       cal_core_sel,
   output logic             cal_stim_enable,
   output logic             offset_cal_active,
   output logic [23:0]      trim
);

   function automatic logic [2:0] onehot(input logic [1:0] idx);
      onehot = 3'(3'b001 << idx);
   endfunction : onehot

   function automatic logic [7:0] pick(input logic [23:0] d, input logic [1:0] idx);
      pick = d[8*idx +: 8];
   endfunction : pick

   acs_state_t     state;
   acs_state_t     next_state;
   logic [15:0]    cnt;
   logic [CTRL_BITS-1:0] ctrl;
   logic [31:0]    delay;
   logic           foreground_cal_done;
   logic           trim_loaded;
   logic [1:0]     slot0;
   logic [1:0]     slot1;
   logic [1:0]     spare;
   logic           swap_slot;
   logic           pin_s1;
   logic           pin_s2;
   logic           pin_s3;
   logic           soft_pulse;
   logic           trig_event;
   logic           swap;
   logic           spare_up;
   logic           bank_phase;
   logic           aw_held;
   logic           w_held;
   logic [7:0]     aw_addr;
   logic [31:0]    w_data;
   logic [3:0]     w_strb;
   logic           do_write;

   ////////////////////////////////////////////////////////////////////////
   // register bus
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && !aw_held) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && !w_held) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr == ADDR_CTRL || aw_addr == ADDR_DELAY
             || aw_addr == ADDR_STATUS || aw_addr == ADDR_TRIM) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctrl       <= CTRL_RESET;
         delay      <= DELAY_RESET;
         soft_pulse <= 1'b0;
      end else begin
         soft_pulse <= do_write && aw_addr == ADDR_CTRL && w_strb[0]
                       && w_data[B_SOFT_TRIG];
         if (do_write && aw_addr == ADDR_CTRL && w_strb[0]) begin
            ctrl <= w_data[CTRL_BITS-1:0];
         end else if (do_write && aw_addr == ADDR_DELAY) begin
            for (int i = 0; i < 4; i++) begin
               if (w_strb[i]) begin
                  delay[8*i +: 8] <= w_data[8*i +: 8];
               end
            end
         end
      end
   end

   // trims take factory values right after reset release
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         trim_loaded <= 1'b0;
         trim        <= 24'h00_0000;
      end else if (!trim_loaded) begin
         trim_loaded <= 1'b1;
         trim        <= factory_trim;
      end else if (do_write && aw_addr == ADDR_TRIM) begin
         for (int i = 0; i < 3; i++) begin
            if (w_strb[i]) begin
               trim[8*i +: 8] <= w_data[8*i +: 8];
            end
         end
      end
   end

   property p_trim_load;
      @(posedge mclk) disable iff (!nrst)
      $rose(trim_loaded) |-> trim == $past(factory_trim);
   endproperty
   a_trim_load: assert property (p_trim_load)
      else $error("trim not loaded from factory value");

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr == ADDR_CTRL) begin
            s_axi_rdata <= {24'h00_0000, ctrl};
         end else if (s_axi_araddr == ADDR_DELAY) begin
            s_axi_rdata <= delay;
         end else if (s_axi_araddr == ADDR_STATUS) begin
            s_axi_rdata <= {24'h00_0000, swap_slot, core_power, spare,
                            state == S_FG, foreground_cal_done};
         end else if (s_axi_araddr == ADDR_TRIM) begin
            s_axi_rdata <= {8'h00, trim};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger source
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
      end else begin
         pin_s1 <= cal_trigger_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   assign trig_event = ctrl[B_PIN_SEL] ? (pin_s2 && !pin_s3) : soft_pulse;

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   assign swap = state == S_BGCAL && ctrl[B_BG_EN] && cnt == CAL_LAST;

   always_comb begin
      next_state = state;
      case (state)
         S_FG: begin
            if (cnt == CAL_LAST) begin
               next_state = S_IDLE;
            end
         end
         S_IDLE: begin
            if (ctrl[B_BG_EN] && !ctrl[B_PIN_SEL] && ctrl[B_SOFT_TRIG]) begin
               next_state = ctrl[B_LOW_POWER_BG_ENABLE] ? S_WAKE : S_BGCAL;
            end else if (trig_event) begin
               next_state = S_FG;
            end
         end
         S_BGCAL: begin
            if (!ctrl[B_BG_EN]) begin
               next_state = S_IDLE;
            end else if (swap && ctrl[B_LOW_POWER_BG_ENABLE]) begin
               next_state = S_SLEEP;
            end
         end
         S_SLEEP: begin
            if (!ctrl[B_BG_EN]) begin
               next_state = S_IDLE;
            end else if (ctrl[B_SWAP_SEL] ? trig_event
                         : cnt == delay[15:0]) begin
               next_state = S_WAKE;
            end
         end
         S_WAKE: begin
            if (!ctrl[B_BG_EN]) begin
               next_state = S_IDLE;
            end else if (cnt == delay[31:16]) begin
               next_state = S_BGCAL;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   // reset state is a foreground run
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= S_FG;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 16'h0000;
      end else if (next_state != state || swap) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         foreground_cal_done <= 1'b0;
      end else if (state == S_FG && cnt == CAL_LAST) begin
         foreground_cal_done <= 1'b1;
      end else if (next_state == S_FG && state != S_FG) begin
         foreground_cal_done <= 1'b0;
      end
   end

   // spare takes over one slot, the replaced core becomes the spare
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slot0     <= CORE_A;
         slot1     <= CORE_B;
         spare     <= CORE_C;
         swap_slot <= 1'b0;
      end else if (swap) begin
         swap_slot <= !swap_slot;
         if (!swap_slot) begin
            slot0 <= spare;
            spare <= slot0;
         end else begin
            slot1 <= spare;
            spare <= slot1;
         end
      end
   end

   property p_fg_powerup;
      @(posedge mclk) disable iff (!nrst)
      $rose(trim_loaded) |-> state == S_FG && cnt == 16'h0001;
   endproperty
   a_fg_powerup: assert property (p_fg_powerup)
      else $error("no foreground run at power-up");

   property p_fg_start;
      @(posedge mclk) disable iff (!nrst)
      state == S_IDLE && trig_event && !ctrl[B_BG_EN] |=> state == S_FG;
   endproperty
   a_fg_start: assert property (p_fg_start)
      else $error("trigger did not start foreground run");

   property p_fg_busy;
      @(posedge mclk) disable iff (!nrst)
      state == S_FG && cnt != CAL_LAST |=> state == S_FG && !foreground_cal_done;
   endproperty
   a_fg_busy: assert property (p_fg_busy)
      else $error("foreground run cut short");

   property p_foreground_cal_done;
      @(posedge mclk) disable iff (!nrst)
      state == S_FG && cnt == CAL_LAST |=> foreground_cal_done && state == S_IDLE;
   endproperty
   a_foreground_cal_done: assert property (p_foreground_cal_done)
      else $error("done not reported after run");

   property p_swap;
      @(posedge mclk) disable iff (!nrst)
      swap |=> spare != $past(spare) && swap_slot != $past(swap_slot);
   endproperty
   a_swap: assert property (p_swap)
      else $error("spare core not rotated");

   property p_sleep;
      @(posedge mclk) disable iff (!nrst)
      state == S_SLEEP && ctrl[B_BG_EN] && !ctrl[B_SWAP_SEL]
      && cnt == delay[15:0] |=> state == S_WAKE;
   endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep delay not honoured");

   property p_wake;
      @(posedge mclk) disable iff (!nrst)
      state == S_WAKE && ctrl[B_BG_EN] && cnt == delay[31:16]
      |=> state == S_BGCAL && cnt == 16'h0000;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake delay not honoured");

   ////////////////////////////////////////////////////////////////////////
   // core control and data path
   assign spare_up        = state == S_WAKE || state == S_BGCAL;
   assign core_power      = ~onehot(spare) | (spare_up ? onehot(spare) : 3'b000);
   assign cal_core_sel    = state == S_FG ? ~onehot(spare)
                          : state == S_BGCAL ? onehot(spare) : 3'b000;
   assign cal_stim_enable = |cal_core_sel;
   assign offset_cal_active = state == S_FG && ctrl[B_OFFS_EN];

   // input select per core: 0 first input, 1 second input
   always_comb begin
      core_input_sel = 3'b000;
      if (ctrl[B_SINGLE]) begin
         core_input_sel = {3{ctrl[B_CHAN_SEL]}};
      end else begin
         core_input_sel = onehot(slot1);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bank_phase <= 1'b0;
      end else begin
         bank_phase <= !bank_phase;
      end
   end

   assign bank_sample = {{2{core_power[2]}}, {2{core_power[1]}}, {2{core_power[0]}}}
                      & {3{bank_phase, !bank_phase}};

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ch_a_data <= MIDCODE;
         ch_b_data <= MIDCODE;
      end else if (state == S_FG) begin
         ch_a_data <= MIDCODE;
         ch_b_data <= MIDCODE;
      end else begin
         ch_a_data <= pick(core_data, slot0);
         ch_b_data <= pick(core_data, slot1);
      end
   end

   property p_midcode;
      @(posedge mclk) disable iff (!nrst)
      state == S_FG |=> ch_a_data == MIDCODE && ch_b_data == MIDCODE;
   endproperty
   a_midcode: assert property (p_midcode)
      else $error("output not midcode during foreground run");

   property p_lp_sleep;
      @(posedge mclk) disable iff (!nrst)
      state == S_SLEEP |-> core_power == ~onehot(spare) && cal_core_sel == 3'b000;
   endproperty
   a_lp_sleep: assert property (p_lp_sleep)
      else $error("sleeping spare core powered");

endmodule : acs_cal_sequencer

// File: core/acs_pkg.sv
/*
 * constants for the core calibration sequencer: register map, control bit
 * positions, reset values, run timing and the sequencer state encoding.
 * assumes a 125 MHz mclk and an AXI4-Lite register bus with 32-bit data.
 */
package acs_pkg;
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_DELAY    = 8'h04;
   localparam logic [7:0]  ADDR_STATUS   = 8'h08;
   localparam logic [7:0]  ADDR_TRIM     = 8'h0C;
   localparam int          B_SOFT_TRIG   = 0;
   localparam int          B_PIN_SEL     = 1;
   localparam int          B_BG_EN       = 2;
   localparam int          B_LOW_POWER_BG_ENABLE       = 3;
   localparam int          B_SWAP_SEL    = 4;
   localparam int          B_OFFS_EN     = 5;
   localparam int          B_SINGLE      = 6;
   localparam int          B_CHAN_SEL    = 7;
   localparam int          CTRL_BITS     = 8;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [31:0] DELAY_RESET   = 32'h0010_0010;
   localparam logic [1:0]  RESP_OKAY     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR   = 2'b10;
   localparam logic [7:0]  MIDCODE       = 8'h00;
   localparam logic [1:0]  CORE_A        = 2'd0;
   localparam logic [1:0]  CORE_B        = 2'd1;
   localparam logic [1:0]  CORE_C        = 2'd2;
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          CAL_RUN_NS    = 2048;
   localparam logic [15:0] CAL_RUN_CYCLES =
      16'((CAL_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] CAL_LAST      = CAL_RUN_CYCLES - 16'd1;

   typedef enum logic [2:0] {
      S_FG    = 3'b000,
      S_IDLE  = 3'b001,
      S_WAKE  = 3'b011,
      S_BGCAL = 3'b010,
      S_SLEEP = 3'b110
   } acs_state_t;
endpackage : acs_pkg

// File: verif/acs_core_model.sv
/*
 * far-side model: the converter cores' sample bytes and the factory trim.
 * assumes it shares mclk and nrst with the sequencer.
 */
`timescale 1ns/10ps
module acs_core_model #(
   parameter logic [23:0] TRIM_VALUE = 24'h5A_3C96
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   output logic [23:0]      core_data,
   output logic [23:0]      factory_trim
);
   logic [7:0] cnt;

   assign factory_trim = TRIM_VALUE;
   // distinct, ever-changing bytes per core so stale or midcode output shows
   assign core_data    = {cnt + 8'h80, cnt + 8'h40, cnt};

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) cnt <= 8'h01;
      else       cnt <= cnt + 8'h01;
   end
endmodule : acs_core_model

// File: verif/acs_cal_sequencer_tb.sv
/*
 * self-checking bench for the calibration sequencer: register table,
 * foreground, pin trigger, background and low-power rotation.
 * assumes the register map and timing of acs_pkg and a 125 MHz mclk.
 */
`timescale 1ns/10ps
module acs_cal_sequencer_tb
   import acs_pkg::*;
;
   logic        mclk = 0, nrst = 0, cal_trigger_pin = 0;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, ch_a_data, ch_b_data;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [23:0] core_data, factory_trim, trim, last_core;
   logic [2:0]  core_power, core_input_sel, cal_core_sel;
   logic [5:0]  bank_sample;
   logic        cal_stim_enable, offset_cal_active;
   int          num_errors = 0, checks_done = 0, n, bad;

   typedef struct {logic [7:0] a; logic [31:0] w, r; logic [1:0] rs; logic [2:0] sel;} acs_row_t;
   acs_row_t rows [6] = '{
      '{ADDR_CTRL, 32'h0000_0040, 32'h0000_0040, RESP_OKAY, 3'b000},
      '{ADDR_CTRL, 32'h0000_00C0, 32'h0000_00C0, RESP_OKAY, 3'b111},
      '{ADDR_CTRL, 32'h0000_0000, 32'h0000_0000, RESP_OKAY, 3'b010},
      '{ADDR_DELAY, 32'h0003_0005, 32'h0003_0005, RESP_OKAY, 3'b010},
      '{ADDR_TRIM, 32'h00AB_CDEF, 32'h00AB_CDEF, RESP_OKAY, 3'b010},
      '{8'h10, 32'h1234_5678, 32'h0000_0000, RESP_SLVERR, 3'b010}};

   always #4 mclk = ~mclk;
   always @(posedge mclk) last_core <= core_data;

   acs_cal_sequencer i_acs_cal_sequencer (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cal_trigger_pin, .core_data,
      .factory_trim, .ch_a_data, .ch_b_data, .core_power, .bank_sample, .core_input_sel,
      .cal_core_sel, .cal_stim_enable, .offset_cal_active, .trim);
   acs_core_model i_acs_core_model (.mclk, .nrst, .core_data, .factory_trim);

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      int   k;
      aw = 1; w = 1; b = 0; k = 0;
      @(posedge mclk);
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (!b && k < 100) begin
         @(posedge mclk);
         k++;
         if (aw && s_axi_awready) begin aw = 0; s_axi_awvalid <= 0; end
         if (w && s_axi_wready) begin w = 0; s_axi_wvalid <= 0; end
         if (s_axi_bvalid) begin b = 1; rsp = s_axi_bresp; s_axi_bready <= 0; end
      end
      if (!b) chk("write answer", 1, 0);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a);
      logic ar, r;
      int   k;
      ar = 1; r = 0; k = 0;
      @(posedge mclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      while (!r && k < 100) begin
         @(posedge mclk);
         k++;
         if (ar && s_axi_arready) begin ar = 0; s_axi_arvalid <= 0; end
         if (s_axi_rvalid) begin r = 1; rd = s_axi_rdata; rsp = s_axi_rresp; s_axi_rready <= 0; end
      end
      if (!r) chk("read answer", 1, 0);
   endtask : axi_read

   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      num_errors++;
      give_verdict();
   end

   initial begin
      repeat (4) @(posedge mclk);
      chk("reset cal sel", 3'b011, cal_core_sel);
      chk("reset power", 3'b011, core_power);
      nrst <= 1;
      repeat (10) @(posedge mclk);
      chk("powerup midcode", MIDCODE, ch_a_data);
      axi_read(ADDR_STATUS);
      chk("powerup busy", 2'b10, rd[1:0]);
      chk("trim load", factory_trim, trim);
      axi_read(ADDR_TRIM);
      chk("trim read", {8'h00, factory_trim}, rd);
      n = 0;
      // host waits for the power-up run before configuring
      while (rd[0] !== 1'b1 && n < 200) begin axi_read(ADDR_STATUS); n++; end
      chk("powerup done", 1, rd[0]);
      foreach (rows[i]) begin
         axi_write(rows[i].a, rows[i].w);
         chk("write resp", rows[i].rs, rsp);
         axi_read(rows[i].a);
         chk("read data", rows[i].r, rd);
         chk("read resp", rows[i].rs, rsp);
         chk("input sel", rows[i].sel, core_input_sel);
      end
      chk("trim port", 24'hAB_CDEF, trim);
      // offset enable before the trigger, then retrigger mid-run
      axi_write(ADDR_CTRL, 32'h0000_0020);
      axi_write(ADDR_CTRL, 32'h0000_0021);
      n = 0;
      while (!offset_cal_active && n < 20) begin @(posedge mclk); n++; end
      chk("stim on", 1, cal_stim_enable);
      bad = 0;
      fork
         begin
            n = 0;
            while (offset_cal_active && n < 400) begin
               @(posedge mclk);
               n++;
               // output register lags the state by one cycle
               if (ch_a_data !== MIDCODE || ch_b_data !== MIDCODE) bad++;
            end
         end
         begin repeat (100) @(posedge mclk); axi_write(ADDR_CTRL, 32'h0000_0021); end
      join
      chk("fg length", CAL_RUN_CYCLES, n);
      chk("fg midcode", 0, bad);
      axi_read(ADDR_STATUS);
      chk("foreground_cal_done", 1, rd[0]);
      // pin trigger
      axi_write(ADDR_CTRL, 32'h0000_0002);
      cal_trigger_pin <= 1;
      n = 0;
      while (cal_core_sel !== 3'b011 && n < 10) begin @(posedge mclk); n++; end
      chk("pin trigger", 3'b011, cal_core_sel);
      chk("offset off", 0, offset_cal_active);
      cal_trigger_pin <= 0;
      n = 0;
      while (cal_core_sel !== 3'b000 && n < 300) begin @(posedge mclk); n++; end
      // background: enable, pin select off, soft trigger
      axi_write(ADDR_CTRL, 32'h0000_0005);
      n = 0;
      while (cal_core_sel !== 3'b100 && n < 10) begin @(posedge mclk); n++; end
      chk("spare cal", 3'b100, cal_core_sel);
      chk("bg power", 3'b111, core_power);
      chk("bg data a", last_core[7:0], ch_a_data);
      n = 0;
      while (cal_core_sel !== 3'b001 && n < 300) begin @(posedge mclk); n++; end
      chk("swap a", 3'b001, cal_core_sel);
      // channel output follows the new slot one cycle later
      @(posedge mclk);
      chk("c takes a", last_core[23:16], ch_a_data);
      chk("b stays", last_core[15:8], ch_b_data);
      axi_read(ADDR_STATUS);
      chk("spare idx", CORE_A, rd[3:2]);
      axi_write(ADDR_CTRL, 32'h0000_0000);
      // low power, dual channel only
      axi_write(ADDR_DELAY, 32'h0008_0004);
      axi_write(ADDR_CTRL, 32'h0000_000D);
      n = 0;
      while (cal_core_sel === 3'b000 && n < 50) begin @(posedge mclk); n++; end
      n = 0;
      while (cal_core_sel !== 3'b000 && n < 300) begin @(posedge mclk); n++; end
      chk("sleep power", 3'b101, core_power);
      chk("sleep banks", 2'b00, bank_sample[3:2]);
      chk("bank phase", 1, ^bank_sample[1:0]);
      n = 0;
      while (core_power !== 3'b111 && n < 50) begin @(posedge mclk); n++; end
      chk("sleep length", 5, n);
      n = 0;
      while (core_power === 3'b111 && cal_core_sel === 3'b000 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      chk("wake length", 9, n);
      // user-paced swap
      axi_write(ADDR_CTRL, 32'h0000_001C);
      n = 0;
      while (cal_core_sel !== 3'b000 && n < 300) begin @(posedge mclk); n++; end
      repeat (40) @(posedge mclk);
      chk("manual asleep", 0, core_power === 3'b111);
      axi_write(ADDR_CTRL, 32'h0000_001D);
      n = 0;
      while (core_power !== 3'b111 && n < 10) begin @(posedge mclk); n++; end
      chk("manual wake", 3'b111, core_power);
      // reset in mid-run: back to a foreground run with factory trims
      nrst <= 0;
      @(posedge mclk);
      chk("rerun reset sel", 3'b011, cal_core_sel);
      chk("rerun reset data", MIDCODE, ch_a_data);
      nrst <= 1;
      repeat (3) @(posedge mclk);
      chk("rerun trim", factory_trim, trim);
      chk("rerun sel", 3'b011, cal_core_sel);
      chk("rerun midcode", MIDCODE, ch_b_data);
      give_verdict();
   end
endmodule : acs_cal_sequencer_tb
